/* File: verilog/frc_pkg.sv */
// shared constants and types for the resume, power-down and identification command block
package frc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // opcodes
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_POWERDOWN = 8'hB9;
    localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
    localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;
    localparam logic [7:0] OP_MFR_DEV_DUAL = 8'h92;
    localparam logic [7:0] OP_MFR_DEV_QUAD = 8'h94;
    localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
    localparam logic [7:0] OP_STD_ID = 8'h9F;
    // frame geometry in serial clocks
    localparam logic [6:0] OPC_CLKS = 7'h08;
    localparam logic [6:0] PRE_RELEASE_ID = 7'h18; // three dummy bytes
    localparam logic [6:0] PRE_MFR_DEV = 7'h18; // 24 address bits, one lane
    localparam logic [6:0] PRE_MFR_DEV_DUAL = 7'h10; // 12 address + 4 mode clocks
    localparam logic [6:0] PRE_MFR_DEV_QUAD = 7'h0C; // 4 dummy + 6 address + 2 mode
    localparam logic [6:0] PRE_UNIQUE_ID = 7'h20; // four dummy bytes
    localparam logic [6:0] PRE_STD_ID = 7'h00;
    localparam logic [6:0] CNT_MAX = 7'h7F;
    localparam logic [6:0] LEN_DEV_ID = 7'h08;
    localparam logic [6:0] LEN_MFR_DEV = 7'h10;
    localparam logic [6:0] LEN_STD_ID = 7'h18;
    localparam logic [6:0] LEN_UNIQUE_ID = 7'h40;
    localparam logic [3:0] OE_N_SINGLE = 4'hD; // only the data-out lane driven
    localparam logic [3:0] OE_N_DUAL = 4'hC;
    localparam logic [3:0] OE_N_QUAD = 4'h0;
    localparam logic [3:0] OE_N_NONE = 4'hF;
    // times in ns; all are longest times, so they round down
    localparam int RESUME_BUSY_NS = 200;
    localparam int SUSPEND_TIME_NS = 20000;
    localparam int POWERDOWN_ENTRY_TIME_NS = 3000;
    localparam int WAKE_TIME_NS = 3000;
    localparam int WAKE_WITH_ID_TIME_NS = 3600; // must stay longer than the plain wake time
    localparam int TMR_W = 10;
    function automatic logic [TMR_W-1:0] max_cyc(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        if (c < 1)
        begin
            c = 1;
        end
        return c[TMR_W-1:0];
    endfunction
    localparam logic [TMR_W-1:0] SUSPEND_CYC = max_cyc(SUSPEND_TIME_NS);
    localparam logic [TMR_W-1:0] PD_ENTRY_CYC = max_cyc(POWERDOWN_ENTRY_TIME_NS);
    localparam logic [TMR_W-1:0] WAKE_CYC = max_cyc(WAKE_TIME_NS);
    localparam logic [TMR_W-1:0] WAKE_ID_CYC = max_cyc(WAKE_WITH_ID_TIME_NS);
    localparam logic [TMR_W-1:0] TMR_ZERO = '0;
    localparam logic [TMR_W-1:0] TMR_ONE = 1;

    typedef enum logic [2:0] {FR_IDLE, FR_OPC, FR_PRE, FR_DATA, FR_IGNORE} frc_frame_t;
    typedef enum logic [1:0] {PW_RUN, PW_ENTER, PW_DOWN, PW_WAKE} frc_power_t;

    // flags reported to the rest of the device
    typedef struct packed {
        logic busy;
        logic suspended;
        logic powerdown;
        logic resume_pulse;
        logic suspend_pulse;
    } frc_status_t;

    // pins of the serial port driven by the device
    typedef struct packed {
        logic [3:0] io;
        logic [3:0] io_oe_n;
    } frc_pins_t;

    typedef struct packed {
        frc_frame_t frame;
        frc_power_t power;
        logic [7:0] op;
        logic [6:0] cnt;
        logic [6:0] idx;
        logic sck_q;
        logic cs_n_q;
        logic sus_lost;
        logic [TMR_W-1:0] sus_tmr;
        logic [TMR_W-1:0] pwr_tmr;
        frc_pins_t pins;
        frc_status_t stat;
    } frc_state_t;
endpackage

/* File: verilog/frc_cmd.sv */
// serial flash command interpreter for resume, power-down and identification reads
`timescale 1ns/100ps
// How it works
// - resume is accepted only with suspend flag set and busy clear.
// - accepted resume clears suspend at once, sets busy within 200ns, work continues.
// - resume with suspend clear or busy set is ignored.
// - resume is ignored when the suspend was broken by power loss.
// - power-down runs only if chip select rises right after the eighth bit.
// - power-down state is entered within the entry time after chip select rises.
// - in power-down only the release/ID opcode is recognised.
// - after reset the device is in normal operation.
// - plain release needs the wake time; nothing is accepted meanwhile.
// - release opcode plus three dummy bytes returns the device ID, repeated.
// - release combined with ID read waits the wake-with-ID time.
// - release/ID opcode is ignored while busy.
// - opcode 90 with 24-bit address returns manufacturer then device ID.
// - opcode 92 takes address on two lanes and returns IDs two bits per clock.
// - opcode 94 takes dummy clocks and address on four lanes, returns four bits.
// - opcode 4B after four dummy bytes returns the 64-bit unique number.
// - opcode 9F returns manufacturer, memory type and capacity bytes.
// - accepted suspend sets suspend flag at once, clears busy within suspend time.
module frc_cmd
    import frc_pkg::*;
#(
    parameter logic [7:0] MFR_ID = 8'hA5, // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h3C, // arbitrary value
    parameter logic [7:0] MEMORY_TYPE_BYTE = 8'h51, // arbitrary value
    parameter logic [7:0] CAPACITY_BYTE = 8'h15, // arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF // arbitrary value
)
(
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic CS_N_I,
    input wire logic SCK_I,
    input wire logic [3:0] IO_I,
    input wire logic OP_START_I,
    input wire logic OP_DONE_I,
    input wire logic POWER_FAIL_I,
    output frc_pkg::frc_pins_t PINS_O,
    output frc_pkg::frc_status_t STATUS_O
);
    import frc_pkg::*;

    frc_state_t s_reg;
    frc_state_t s_next;

    // the timers hold their counts in TMR_W bits; busy rises one clock after a resume
    if (SUSPEND_CYC == TMR_ZERO || PD_ENTRY_CYC == TMR_ZERO || WAKE_CYC == TMR_ZERO ||
        WAKE_ID_CYC == TMR_ZERO || CLK_PERIOD_NS > RESUME_BUSY_NS)
    begin : g_bad_timing
        $error("frc_cmd: timing count does not fit the timer");
    end

    // preamble clocks between opcode and first output bit
    function automatic logic [6:0] pre_clks(input logic [7:0] op);
        case (op)
            OP_RELEASE_ID: return PRE_RELEASE_ID;
            OP_MFR_DEV_ID: return PRE_MFR_DEV;
            OP_MFR_DEV_DUAL: return PRE_MFR_DEV_DUAL;
            OP_MFR_DEV_QUAD: return PRE_MFR_DEV_QUAD;
            OP_UNIQUE_ID: return PRE_UNIQUE_ID;
            default: return PRE_STD_ID;
        endcase
    endfunction

    // number of data lanes used for the answer
    function automatic int lanes(input logic [7:0] op);
        case (op)
            OP_MFR_DEV_DUAL: return 2;
            OP_MFR_DEV_QUAD: return 4;
            default: return 1;
        endcase
    endfunction

    // answer length in bits before it wraps round
    function automatic logic [6:0] pat_len(input logic [7:0] op);
        case (op)
            OP_RELEASE_ID: return LEN_DEV_ID;
            OP_STD_ID: return LEN_STD_ID;
            OP_UNIQUE_ID: return LEN_UNIQUE_ID;
            default: return LEN_MFR_DEV;
        endcase
    endfunction

    // next bits of the answer, msb first, packed into the low lanes
    function automatic logic [3:0] get_bits(input logic [7:0] op, input logic [6:0] idx);
        logic [63:0] pat;
        logic [3:0] r;
        int l;
        int pos;
        r = 4'h0;
        l = lanes(op);
        case (op)
            OP_RELEASE_ID: pat = {DEVICE_ID, 56'h0};
            OP_STD_ID: pat = {MFR_ID, MEMORY_TYPE_BYTE, CAPACITY_BYTE, 40'h0};
            OP_UNIQUE_ID: pat = UNIQUE_ID;
            default: pat = {MFR_ID, DEVICE_ID, 48'h0};
        endcase
        for (int k = 0; k < 4; k++)
        begin
            pos = 63 - int'(idx) - k;
            if (k < l && pos >= 0)
            begin
                r[l-1-k] = pat[pos];
            end
        end
        return r;
    endfunction

    // next-state logic for frame decode, flags and power state
    always_comb
    begin
        logic cs_fall;
        logic cs_rise;
        logic sck_rise;
        logic sck_fall;
        logic [7:0] nop;
        logic [3:0] b;
        logic [6:0] nidx;
        s_next = s_reg;
        s_next.sck_q = SCK_I;
        s_next.cs_n_q = CS_N_I;
        s_next.stat.resume_pulse = 1'b0;
        s_next.stat.suspend_pulse = 1'b0;
        cs_fall = s_reg.cs_n_q && !CS_N_I;
        cs_rise = !s_reg.cs_n_q && CS_N_I;
        sck_rise = !s_reg.sck_q && SCK_I && !CS_N_I;
        sck_fall = s_reg.sck_q && !SCK_I && !CS_N_I;
        nop = {s_reg.op[6:0], IO_I[0]};
        b = 4'h0;
        nidx = 7'h00;

        // suspend settle timer drops busy when it expires
        if (s_reg.sus_tmr != TMR_ZERO)
        begin
            s_next.sus_tmr = s_reg.sus_tmr - TMR_ONE;
            if (s_reg.sus_tmr == TMR_ONE)
            begin
                s_next.stat.busy = 1'b0;
            end
        end
        if (OP_DONE_I)
        begin
            s_next.stat.busy = 1'b0;
        end
        if (OP_START_I)
        begin
            s_next.stat.busy = 1'b1; // a start wins over a finish in the same cycle
        end
        if (POWER_FAIL_I && s_reg.stat.suspended)
        begin
            s_next.sus_lost = 1'b1;
        end

        // power state timers
        case (s_reg.power)
            PW_ENTER, PW_WAKE:
            begin
                s_next.pwr_tmr = s_reg.pwr_tmr - TMR_ONE;
                if (s_reg.pwr_tmr == TMR_ONE)
                begin
                    s_next.power = (s_reg.power == PW_ENTER) ? PW_DOWN : PW_RUN;
                    s_next.stat.powerdown = (s_reg.power == PW_ENTER);
                end
            end
            default: ;
        endcase

        // frame sequencing on the serial port
        case (s_reg.frame)
            FR_OPC:
            begin
                if (sck_rise)
                begin
                    s_next.op = nop;
                    s_next.cnt = (s_reg.cnt == CNT_MAX) ? CNT_MAX : s_reg.cnt + 7'h01;
                    if (s_reg.cnt == OPC_CLKS - 7'h01)
                    begin
                        if (s_reg.power == PW_DOWN && nop != OP_RELEASE_ID)
                        begin
                            s_next.frame = FR_IGNORE;
                        end
                        else if (nop == OP_RELEASE_ID && s_reg.stat.busy)
                        begin
                            s_next.frame = FR_IGNORE;
                        end
                        else
                        begin
                            case (nop)
                                OP_STD_ID:
                                begin
                                    s_next.frame = FR_DATA;
                                    s_next.idx = 7'h00;
                                end
                                OP_RELEASE_ID, OP_MFR_DEV_ID, OP_MFR_DEV_DUAL,
                                OP_MFR_DEV_QUAD, OP_UNIQUE_ID:
                                begin
                                    s_next.frame = FR_PRE;
                                end
                                OP_SUSPEND, OP_RESUME, OP_POWERDOWN: ;
                                default: s_next.frame = FR_IGNORE;
                            endcase
                        end
                    end
                end
            end
            FR_PRE:
            begin
                if (sck_rise)
                begin
                    s_next.cnt = s_reg.cnt + 7'h01;
                    if (s_reg.cnt + 7'h01 == OPC_CLKS + pre_clks(s_reg.op))
                    begin
                        s_next.frame = FR_DATA;
                        s_next.idx = 7'h00;
                    end
                end
            end
            FR_DATA:
            begin
                if (sck_rise)
                begin
                    s_next.cnt = (s_reg.cnt == CNT_MAX) ? CNT_MAX : s_reg.cnt + 7'h01;
                end
                if (sck_fall)
                begin
                    b = get_bits(s_reg.op, s_reg.idx);
                    nidx = s_reg.idx + 7'(lanes(s_reg.op));
                    s_next.idx = (nidx >= pat_len(s_reg.op)) ? 7'h00 : nidx;
                    case (lanes(s_reg.op))
                        2:
                        begin
                            s_next.pins.io = {2'b00, b[1:0]};
                            s_next.pins.io_oe_n = OE_N_DUAL;
                        end
                        4:
                        begin
                            s_next.pins.io = b;
                            s_next.pins.io_oe_n = OE_N_QUAD;
                        end
                        default:
                        begin
                            s_next.pins.io = {2'b00, b[0], 1'b0};
                            s_next.pins.io_oe_n = OE_N_SINGLE;
                        end
                    endcase
                end
            end
            default: ;
        endcase

        // chip select rising: execute eight-bit commands and end every read
        if (cs_rise)
        begin
            s_next.frame = FR_IDLE;
            s_next.pins.io = 4'h0;
            s_next.pins.io_oe_n = OE_N_NONE;
            if (s_reg.frame == FR_OPC && s_reg.cnt == OPC_CLKS)
            begin
                case (s_reg.op)
                    OP_POWERDOWN:
                    begin
                        s_next.power = PW_ENTER;
                        s_next.pwr_tmr = PD_ENTRY_CYC;
                    end
                    OP_SUSPEND:
                    begin
                        if (!s_reg.stat.suspended && s_reg.stat.busy)
                        begin
                            s_next.stat.suspended = 1'b1;
                            s_next.stat.suspend_pulse = 1'b1;
                            s_next.sus_tmr = SUSPEND_CYC;
                            s_next.sus_lost = 1'b0;
                        end
                    end
                    OP_RESUME:
                    begin
                        if (s_reg.stat.suspended && !s_reg.stat.busy && !s_reg.sus_lost)
                        begin
                            s_next.stat.suspended = 1'b0;
                            s_next.stat.busy = 1'b1;
                            s_next.stat.resume_pulse = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            if (s_reg.power == PW_DOWN && s_reg.op == OP_RELEASE_ID &&
                (s_reg.frame == FR_OPC || s_reg.frame == FR_PRE || s_reg.frame == FR_DATA))
            begin
                s_next.power = PW_WAKE;
                s_next.pwr_tmr = (s_reg.cnt == OPC_CLKS) ? WAKE_CYC : WAKE_ID_CYC;
            end
        end
        else if (cs_fall)
        begin
            s_next.cnt = 7'h00;
            s_next.op = 8'h00;
            // no command is taken while entering or leaving power-down
            s_next.frame = (s_reg.power == PW_ENTER || s_reg.power == PW_WAKE) ?
                FR_IGNORE : FR_OPC;
        end
    end

    // state register; reset puts the device in normal operation
    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            s_reg <= '{frame: FR_IDLE, power: PW_RUN, op: 8'h00, cnt: 7'h00, idx: 7'h00,
                sck_q: 1'b0, cs_n_q: 1'b1, sus_lost: 1'b0, sus_tmr: TMR_ZERO,
                pwr_tmr: TMR_ZERO, pins: '{io: 4'h0, io_oe_n: OE_N_NONE},
                stat: '{busy: 1'b0, suspended: 1'b0, powerdown: 1'b0,
                resume_pulse: 1'b0, suspend_pulse: 1'b0}};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign PINS_O = s_reg.pins;
    assign STATUS_O = s_reg.stat;
endmodule

/* File: verif/frc_props.sv */
// checker for the resume, power-down and identification command block
`timescale 1ns/100ps
module frc_props
    import frc_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic CS_N_I,
    input wire logic SCK_I,
    input wire logic [3:0] IO_I,
    input wire logic OP_START_I,
    input wire logic OP_DONE_I,
    input wire logic POWER_FAIL_I,
    input wire frc_pkg::frc_pins_t PINS_O,
    input wire frc_pkg::frc_status_t STATUS_O
);
    logic [6:0] cs_age;
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!NRST_I);
    // cycles since chip select was seen rising, saturating
    always_ff @(posedge CLOCK_I or negedge NRST_I)
        if (!NRST_I)
            cs_age <= 7'h00;
        else if ($rose(CS_N_I))
            cs_age <= 7'h00;
        else if (cs_age != 7'h7F)
            cs_age <= cs_age + 7'h01;
    // flag and lane relations
    a_reset_idle: assert property ($rose(NRST_I) |-> STATUS_O == '0)
        else $error("status not idle after reset");
    a_cs_ends_read: assert property ($rose(CS_N_I) |=> PINS_O.io_oe_n == 4'hF)
        else $error("lanes enabled after select rose");
    a_out_on_fall: assert property (!$stable(PINS_O.io) |->
        ($past(SCK_I, 2) && !$past(SCK_I)) || ($past(CS_N_I) && !$past(CS_N_I, 2)))
        else $error("data changed off a clock fall");
    a_resume_flags: assert property (STATUS_O.resume_pulse |->
        STATUS_O.busy && !STATUS_O.suspended
        && $past(STATUS_O.suspended) && !$past(STATUS_O.busy))
        else $error("resume taken with wrong flags");
    a_resume_once: assert property (STATUS_O.resume_pulse |=> !STATUS_O.resume_pulse)
        else $error("resume pulse too long");
    a_suspend_flags: assert property (STATUS_O.suspend_pulse |->
        STATUS_O.suspended && !$past(STATUS_O.suspended) && $past(STATUS_O.busy))
        else $error("suspend taken with wrong flags");
    a_suspend_idle: assert property ($rose(STATUS_O.suspended) |->
        STATUS_O.suspended throughout (1'b1 ##[1:501] !STATUS_O.busy))
        else $error("busy not cleared in suspend time");
    a_pd_deaf: assert property (STATUS_O.powerdown |->
        !STATUS_O.resume_pulse && !STATUS_O.suspend_pulse)
        else $error("command taken in power-down");
    a_pd_entry: assert property ($rose(STATUS_O.powerdown) |->
        cs_age >= 7'h46 && cs_age <= 7'h50)
        else $error("power-down entry time wrong");
    a_wake_time: assert property ($fell(STATUS_O.powerdown) |->
        {3'b000, cs_age} == WAKE_CYC || {3'b000, cs_age} == WAKE_ID_CYC)
        else $error("wake time wrong");
    // main scenarios reached
    c_resume: cover property (STATUS_O.resume_pulse);
    c_suspend: cover property (STATUS_O.suspend_pulse);
    c_pd: cover property ($rose(STATUS_O.powerdown));
    c_quad: cover property (PINS_O.io_oe_n == 4'h0);
endmodule
bind frc_cmd frc_props i_props (.CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .CS_N_I(CS_N_I),
    .SCK_I(SCK_I), .IO_I(IO_I), .OP_START_I(OP_START_I), .OP_DONE_I(OP_DONE_I),
    .POWER_FAIL_I(POWER_FAIL_I), .PINS_O(PINS_O), .STATUS_O(STATUS_O));

/* File: verif/frc_host.sv */
// host serial controller model: frames opcodes and collects answers
`timescale 1ns/100ps
module frc_host
    import frc_pkg::*;
(
    input wire logic clk_i,
    input wire frc_pkg::frc_pins_t pins_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic [3:0] io_o
);
    logic [63:0] rx_word;
    event got;
    int cyc = 0;
    int last_res = -1000;
    // idle lines and a cycle count for the suspend guard
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        io_o = 4'h0;
    end
    always @(posedge clk_i)
        cyc <= cyc + 1;
    // preamble lanes: zero address, mode upper nibble all ones, random dummies
    function automatic logic [3:0] pre_io(input logic [7:0] op, input int j);
        logic [3:0] r;
        r = 4'($urandom);
        if (op == OP_MFR_DEV_ID)
            r = 4'h0;
        else if (op == OP_MFR_DEV_DUAL)
            r = (j < 12) ? 4'h0 : (j < 14) ? 4'h3 : r & 4'h3;
        else if (op == OP_MFR_DEV_QUAD)
            r = (j > 3 && j < 10) ? 4'h0 : (j == 10) ? 4'hF : r;
        return r;
    endfunction
    // n serial clocks, each level held two cycles; answer bits taken from clock skip on
    task automatic frame(input logic [7:0] op, input int n, input int skip, input int lanes);
        logic [63:0] rx;
        rx = '0;
        if (op == OP_SUSPEND)
            wait (cyc - last_res > int'(SUSPEND_CYC));
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            sck_o <= 1'b0;
            io_o <= (i < 8) ? {3'($urandom), op[7 - i]} : pre_io(op, i - 8);
            repeat (2) @(posedge clk_i);
            sck_o <= 1'b1;
            @(negedge clk_i);
            if (i >= skip)
                rx = (lanes == 1) ? {rx[62:0], pins_i.io[1]} : (lanes == 2) ?
                    {rx[61:0], pins_i.io[1:0]} : {rx[59:0], pins_i.io};
            @(posedge clk_i);
        end
        @(posedge clk_i);
        sck_o <= 1'b0;
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        io_o <= ~io_o;
        rx_word = rx;
        if (n > skip)
            ->got;
        if (op == OP_RESUME)
            last_res = cyc;
        if (op != OP_RELEASE_ID)
            repeat (3) @(posedge clk_i);
        else
            repeat (int'(n > 8 ? WAKE_ID_CYC : WAKE_CYC) + 3) @(posedge clk_i);
    endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the resume, power-down and identification command block
`timescale 1ns/100ps
module tb;
    import frc_pkg::*;
    localparam logic [7:0] MFR = 8'h6D; // arbitrary value
    localparam logic [7:0] DEV = 8'h2E; // arbitrary value
    localparam logic [7:0] MTYPE = 8'h47; // arbitrary value
    localparam logic [7:0] CAP = 8'h19; // arbitrary value
    localparam logic [63:0] UID = 64'hFEDCBA9876543210; // arbitrary value
    logic clk, nrst, cs_n, sck;
    logic [3:0] io;
    logic [2:0] eng;
    frc_pins_t pins;
    frc_status_t stat;
    logic [63:0] exp_q[$];
    int miscompares = 0;
    int n_checks = 0;
    frc_cmd #(.MFR_ID(MFR), .DEVICE_ID(DEV), .MEMORY_TYPE_BYTE(MTYPE), .CAPACITY_BYTE(CAP),
        .UNIQUE_ID(UID)) i_dut (.CLOCK_I(clk), .NRST_I(nrst), .CS_N_I(cs_n), .SCK_I(sck),
        .IO_I(io), .OP_START_I(eng[0]), .OP_DONE_I(eng[1]), .POWER_FAIL_I(eng[2]),
        .PINS_O(pins), .STATUS_O(stat));
    frc_host i_host (.clk_i(clk), .pins_i(pins), .cs_n_o(cs_n), .sck_o(sck), .io_o(io));
    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cmp_word(input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // flags read mid-cycle, after the edge updates have landed
    task automatic cmp_stat(input logic [2:0] e);
        @(negedge clk);
        cmp_word({61'h0, e}, {61'h0, stat.busy, stat.suspended, stat.powerdown});
    endtask
    task automatic rd(input logic [7:0] op, input int pre, input int n, input int lanes,
        input logic [63:0] e);
        exp_q.push_back(e);
        i_host.frame(op, 8 + pre + n, 8 + pre, lanes);
    endtask
    // engine pulses: start, done, power fail
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        eng <= m;
        @(posedge clk);
        eng <= 3'h0;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // oldest note against each collected answer
    initial
        forever
        begin
            @(i_host.got);
            cmp_word(exp_q.pop_front(), i_host.rx_word);
        end
    // watchdog well above the expected run of some 4700 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        miscompares++;
        end_of_test;
    end
    // test sequence
    initial
    begin
        nrst = 1'b0;
        eng = 3'h0;
        void'($urandom(32'hB59E));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        cmp_stat(3'h0);
        $display("reset test done");
        rd(OP_STD_ID, 0, 32, 1, {32'h0, MFR, MTYPE, CAP, MFR});
        rd(OP_STD_ID, 0, 4, 1, {60'h0, MFR[7:4]});
        rd(OP_STD_ID, 0, 8, 1, {56'h0, MFR});
        rd(OP_MFR_DEV_ID, 24, 24, 1, {40'h0, MFR, DEV, MFR});
        rd(OP_MFR_DEV_DUAL, 16, 16, 2, {32'h0, MFR, DEV, MFR, DEV});
        rd(OP_MFR_DEV_QUAD, 12, 8, 4, {32'h0, MFR, DEV, MFR, DEV});
        rd(OP_UNIQUE_ID, 32, 64, 1, UID);
        rd(OP_RELEASE_ID, 24, 16, 1, {48'h0, DEV, DEV});
        $display("id test done");
        i_host.frame(OP_RESUME, 8, 8, 1);
        cmp_stat(3'h0);
        pulse(3'h1);
        pulse(3'h2);
        cmp_stat(3'h0);
        pulse(3'h1);
        i_host.frame(OP_RESUME, 8, 8, 1);
        cmp_stat(3'h4);
        rd(OP_RELEASE_ID, 24, 16, 1, 64'h0);
        i_host.frame(OP_SUSPEND, 8, 8, 1);
        cmp_stat(3'h6);
        repeat (510) @(posedge clk);
        cmp_stat(3'h2);
        i_host.frame(OP_RESUME, 8, 8, 1);
        cmp_stat(3'h4);
        i_host.frame(OP_SUSPEND, 8, 8, 1);
        repeat (510) @(posedge clk);
        pulse(3'h4);
        i_host.frame(OP_RESUME, 8, 8, 1);
        cmp_stat(3'h2);
        $display("resume test done");
        i_host.frame(OP_POWERDOWN, 7, 8, 1);
        i_host.frame(OP_POWERDOWN, 9, 9, 1);
        repeat (80) @(posedge clk);
        cmp_stat(3'h2);
        i_host.frame(OP_POWERDOWN, 8, 8, 1);
        repeat (80) @(posedge clk);
        cmp_stat(3'h3);
        rd(OP_STD_ID, 0, 8, 1, 64'h0);
        i_host.frame(OP_RESUME, 8, 8, 1);
        cmp_stat(3'h3);
        i_host.frame(OP_RELEASE_ID, 8, 8, 1);
        cmp_stat(3'h2);
        i_host.frame(OP_POWERDOWN, 8, 8, 1);
        repeat (80) @(posedge clk);
        rd(OP_RELEASE_ID, 24, 16, 1, {48'h0, DEV, DEV});
        cmp_stat(3'h2);
        $display("power-down test done");
        end_of_test;
    end
endmodule
